// [common/gocmd_pkg.sv]
`default_nettype none
package gocmd_pkg;
    localparam logic [7:0] OP_POWER = 8'h10;
    localparam logic [7:0] OP_DISPLAY = 8'h11;
    localparam logic [7:0] OP_LOWLAT = 8'h12;
    localparam logic [7:0] OP_LOOK = 8'h13;
    localparam logic [7:0] OP_RESOURCE = 8'hF2;
    localparam logic [7:0] OP_FREEAREA = 8'hFF;
    localparam logic [3:0] RESOURCE_LEN = 4'hC;
    localparam int RES_KINDS = 6;
    localparam logic [3:0] FREE_LEN = 4'h2;
    localparam logic [3:0] ONE_LEN = 4'h1;
    localparam logic [3:0] TWO_LEN = 4'h2;
    localparam logic [7:0] SRC_EXTERNAL = 8'h00;
    localparam logic [7:0] SRC_TEST = 8'h01;
    localparam logic [7:0] SRC_SOLID = 8'h02;
    localparam logic [7:0] SRC_SPLASH = 8'h03;
    localparam logic [7:0] SRC_CURTAIN = 8'h04;
    localparam logic [7:0] PWR_RESET = 8'h00;
    localparam logic [7:0] PWR_STANDBY = 8'h01;
    localparam logic [7:0] PWR_ACTIVE = 8'h02;
    localparam logic [7:0] PWR_COOLING = 8'h03;
    localparam logic [7:0] PWR_WARMING = 8'h04;
    localparam int LOWLAT_BIT = 0;
    localparam logic [7:0] LOWLAT_MASK = 8'h01;
    localparam logic [15:0] LOOK_RESET = 16'h0000;
    typedef enum logic [3:0] {
        GOC_IDLE = 4'b0001,
        GOC_ARGS = 4'b0010,
        GOC_EXEC = 4'b0100,
        GOC_REPLY = 4'b1000
    } goc_state_type;
endpackage
`default_nettype wire

// [core/gocmd_handler.sv]
`default_nettype none
// Notes on behaviour
// - Resource query returns twelve bytes, peaks first.
// - Bytes six to eleven carry present counts.
// - Free-area query returns two-byte offset.
// - Power set: standby to active, active to down.
// - Standby is the low-power mode.
// - Power read returns one-byte state code.
// - Display set selects one of five sources.
// - Absent external source falls back by default.
// - Display read returns source being shown.
// - Low-latency bit zero enables or disables.
// - Low latency bounds delay to 1.5 frames.
// - Low-latency read returns current enable.
// - Look set loads sequences for index.
// - New look starts source definition change.
// - Look read returns active look index.
module gocmd_handler (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic cmd_write,
    output logic cmd_ready,
    input wire logic arg_valid,
    input wire logic [7:0] arg_data,
    output logic arg_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_last,
    input wire logic rsp_ready,
    input wire logic [47:0] res_peak,
    input wire logic [47:0] res_now,
    input wire logic [15:0] free_offset,
    input wire logic source_present_pin,
    input wire logic fallback_splash,
    input wire logic power_done,
    output logic [7:0] power_state,
    output logic low_power,
    output logic [7:0] source_sel,
    output logic [7:0] shown_source,
    output logic low_latency_en,
    output logic [15:0] look_index,
    output logic look_load,
    output logic source_def_change
);
    // =====================================================================
    // Decoding
    function automatic logic [3:0] arg_len(input logic [7:0] op);
        case (op)
            gocmd_pkg::OP_POWER: arg_len = '0;
            gocmd_pkg::OP_DISPLAY: arg_len = gocmd_pkg::ONE_LEN;
            gocmd_pkg::OP_LOWLAT: arg_len = gocmd_pkg::ONE_LEN;
            gocmd_pkg::OP_LOOK: arg_len = gocmd_pkg::TWO_LEN;
            default: arg_len = '0;
        endcase
    endfunction

    function automatic logic [3:0] rsp_len(input logic [7:0] op);
        case (op)
            gocmd_pkg::OP_POWER: rsp_len = gocmd_pkg::ONE_LEN;
            gocmd_pkg::OP_DISPLAY: rsp_len = gocmd_pkg::ONE_LEN;
            gocmd_pkg::OP_LOWLAT: rsp_len = gocmd_pkg::ONE_LEN;
            gocmd_pkg::OP_LOOK: rsp_len = gocmd_pkg::TWO_LEN;
            gocmd_pkg::OP_RESOURCE: rsp_len = gocmd_pkg::RESOURCE_LEN;
            gocmd_pkg::OP_FREEAREA: rsp_len = gocmd_pkg::FREE_LEN;
            default: rsp_len = '0;
        endcase
    endfunction

    gocmd_pkg::goc_state_type state_r;
    logic [7:0] op_r;
    logic wr_r;
    logic [3:0] cnt_r;
    logic [15:0] arg_r;
    logic [7:0] res_bytes [0:11];
    logic src_present;

    gocmd_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .din(source_present_pin),
        .dout(src_present)
    );

    // peaks in bytes 0..5, present counts in bytes 6..11.
    genvar gi;
    generate
        for (gi = 0; gi < gocmd_pkg::RES_KINDS; gi++)
        begin : g_res
            assign res_bytes[gi] = res_peak[gi*8 +: 8];
            assign res_bytes[gi + gocmd_pkg::RES_KINDS] = res_now[gi*8 +: 8];
        end
    endgenerate

    assign cmd_ready = (state_r == gocmd_pkg::GOC_IDLE);
    assign arg_ready = (state_r == gocmd_pkg::GOC_ARGS);

    // =====================================================================
    // Command sequencing
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r <= gocmd_pkg::GOC_IDLE;
            op_r <= '0;
            wr_r <= 1'b0;
            cnt_r <= '0;
            arg_r <= '0;
        end
        else if (ce)
        begin
            case (state_r)
                gocmd_pkg::GOC_IDLE:
                begin
                    cnt_r <= '0;
                    if (cmd_valid)
                    begin
                        op_r <= cmd_opcode;
                        wr_r <= cmd_write;
                        state_r <= (cmd_write && arg_len(cmd_opcode) != '0)
                            ? gocmd_pkg::GOC_ARGS : gocmd_pkg::GOC_EXEC;
                    end
                end
                gocmd_pkg::GOC_ARGS:
                begin
                    if (arg_valid)
                    begin
                        // Little-endian multi-byte arguments.
                        arg_r[cnt_r[0]*8 +: 8] <= arg_data;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r + 4'h1 == arg_len(op_r))
                        begin
                            state_r <= gocmd_pkg::GOC_EXEC;
                        end
                    end
                end
                gocmd_pkg::GOC_EXEC:
                begin
                    cnt_r <= '0;
                    state_r <= (!wr_r && rsp_len(op_r) != '0)
                        ? gocmd_pkg::GOC_REPLY : gocmd_pkg::GOC_IDLE;
                end
                gocmd_pkg::GOC_REPLY:
                begin
                    if (rsp_valid && rsp_ready)
                    begin
                        cnt_r <= cnt_r + 4'h1;
                        if (rsp_last)
                        begin
                            state_r <= gocmd_pkg::GOC_IDLE;
                        end
                    end
                end
                default: state_r <= gocmd_pkg::GOC_IDLE;
            endcase
        end
    end

    logic exec_wr;
    assign exec_wr = (state_r == gocmd_pkg::GOC_EXEC) && wr_r;

    // =====================================================================
    // Power state
    // Warming and cooling end when the power sequencer reports completion.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            power_state <= gocmd_pkg::PWR_STANDBY;
        end
        else if (ce)
        begin
            if (exec_wr && op_r == gocmd_pkg::OP_POWER)
            begin
                if (power_state == gocmd_pkg::PWR_STANDBY)
                begin
                    power_state <= gocmd_pkg::PWR_WARMING;
                end
                else if (power_state == gocmd_pkg::PWR_ACTIVE)
                begin
                    power_state <= gocmd_pkg::PWR_COOLING;
                end
            end
            else if (power_done && power_state == gocmd_pkg::PWR_WARMING)
            begin
                power_state <= gocmd_pkg::PWR_ACTIVE;
            end
            else if (power_done && power_state == gocmd_pkg::PWR_COOLING)
            begin
                power_state <= gocmd_pkg::PWR_STANDBY;
            end
        end
    end

    assign low_power = (power_state == gocmd_pkg::PWR_STANDBY);

    // =====================================================================
    // Display source, low latency and look
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            source_sel <= gocmd_pkg::SRC_EXTERNAL;
            low_latency_en <= 1'b0;
            look_index <= gocmd_pkg::LOOK_RESET;
            look_load <= 1'b0;
            source_def_change <= 1'b0;
        end
        else if (ce)
        begin
            look_load <= 1'b0;
            source_def_change <= 1'b0;
            if (exec_wr && op_r == gocmd_pkg::OP_DISPLAY
                && arg_r[7:0] <= gocmd_pkg::SRC_CURTAIN)
            begin
                source_sel <= arg_r[7:0];
            end
            if (exec_wr && op_r == gocmd_pkg::OP_LOWLAT)
            begin
                low_latency_en <= arg_r[gocmd_pkg::LOWLAT_BIT];
            end
            if (exec_wr && op_r == gocmd_pkg::OP_LOOK)
            begin
                look_index <= arg_r;
                look_load <= 1'b1;
                source_def_change <= 1'b1;
            end
        end
    end

    // Shown source lags selection by one cycle so the fallback is glitch free.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            shown_source <= gocmd_pkg::SRC_EXTERNAL;
        end
        else if (ce)
        begin
            shown_source <= (source_sel == gocmd_pkg::SRC_EXTERNAL && !src_present)
                ? (fallback_splash ? gocmd_pkg::SRC_SPLASH : gocmd_pkg::SRC_SOLID)
                : source_sel;
        end
    end

    // =====================================================================
    // Reply bytes
    // Byte i of the reply to the latched opcode; two-byte values go low byte first.
    function automatic logic [7:0] reply_byte(input logic [3:0] i);
        case (op_r)
            gocmd_pkg::OP_POWER: reply_byte = power_state;
            gocmd_pkg::OP_DISPLAY: reply_byte = shown_source;
            gocmd_pkg::OP_LOWLAT: reply_byte = {7'h0, low_latency_en};
            gocmd_pkg::OP_LOOK: reply_byte = look_index[i[0]*8 +: 8];
            gocmd_pkg::OP_RESOURCE: reply_byte = res_bytes[i];
            gocmd_pkg::OP_FREEAREA: reply_byte = free_offset[i[0]*8 +: 8];
            default: reply_byte = '0;
        endcase
    endfunction

    // Reply data is registered; byte 0 is loaded in GOC_EXEC, then byte cnt_r + 1 whenever byte cnt_r is accepted.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            rsp_last <= 1'b0;
        end
        else if (ce)
        begin
            if (state_r == gocmd_pkg::GOC_EXEC && !wr_r && rsp_len(op_r) != '0)
            begin
                rsp_valid <= 1'b1;
                rsp_data <= reply_byte(4'h0);
                rsp_last <= (rsp_len(op_r) == gocmd_pkg::ONE_LEN);
            end
            else if (rsp_valid && rsp_ready)
            begin
                if (rsp_last)
                begin
                    rsp_valid <= 1'b0;
                    rsp_last <= 1'b0;
                end
                else
                begin
                    rsp_data <= reply_byte(cnt_r + 4'h1);
                    rsp_last <= (cnt_r + 4'h2 == rsp_len(op_r));
                end
            end
        end
    end
endmodule
`default_nettype wire

// [core/gocmd_sync.sv]
`default_nettype none
// Three-stage pin synchroniser; a change is taken once stages two and three agree.
module gocmd_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end
        else if (ce)
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
            begin
                dout <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/gocmd_handler_asserts.sv]
`default_nettype none
module gocmd_handler_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    input wire logic rsp_ready,
    input wire logic source_present_pin,
    input wire logic fallback_splash,
    input wire logic [7:0] power_state,
    input wire logic low_power,
    input wire logic [7:0] source_sel,
    input wire logic [7:0] shown_source,
    input wire logic [15:0] look_index,
    input wire logic look_load,
    input wire logic source_def_change
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ========================================
    // Sequences and properties
    // Eight cycles covers the pin synchroniser plus the one-cycle display register.
    sequence s_absent;
        (!source_present_pin && source_sel == gocmd_pkg::SRC_EXTERNAL
            && $stable(fallback_splash))[*8];
    endsequence
    property p_fallback;
        s_absent |-> shown_source == (fallback_splash ? gocmd_pkg::SRC_SPLASH
            : gocmd_pkg::SRC_SOLID);
    endproperty
    property p_low_power;
        low_power == (power_state == gocmd_pkg::PWR_STANDBY);
    endproperty
    property p_power_code;
        power_state <= gocmd_pkg::PWR_WARMING;
    endproperty
    property p_to_active;
        $changed(power_state) && power_state == gocmd_pkg::PWR_ACTIVE
            |-> $past(power_state) == gocmd_pkg::PWR_WARMING;
    endproperty
    property p_sel_range;
        source_sel <= gocmd_pkg::SRC_CURTAIN;
    endproperty
    property p_shown;
        $stable(source_sel) && source_sel != gocmd_pkg::SRC_EXTERNAL
            |-> shown_source == source_sel;
    endproperty
    property p_look;
        $changed(look_index) |-> look_load && source_def_change;
    endproperty
    property p_pulse;
        look_load |-> source_def_change ##1 !look_load;
    endproperty
    property p_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback source wrong");
    a_low_power: assert property (p_low_power) else $error("low power flag wrong");
    a_power_code: assert property (p_power_code) else $error("bad power code");
    a_to_active: assert property (p_to_active) else $error("bad path to active");
    a_sel_range: assert property (p_sel_range) else $error("bad source kept");
    a_shown: assert property (p_shown) else $error("shown source wrong");
    a_look: assert property (p_look) else $error("look changed silently");
    a_pulse: assert property (p_pulse) else $error("look pulse wrong");
    a_hold: assert property (p_hold) else $error("reply byte not held");
endmodule
bind gocmd_handler gocmd_handler_asserts u_chk (.clk, .nrst, .rsp_valid, .rsp_data,
    .rsp_last, .rsp_ready, .source_present_pin, .fallback_splash, .power_state,
    .low_power, .source_sel, .shown_source, .look_index, .look_load, .source_def_change);
`default_nettype wire

// [dv/gocmd_host.sv]
`default_nettype none
module gocmd_host (
    input wire logic clk,
    input wire logic cmd_ready,
    input wire logic arg_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic cmd_write,
    output logic arg_valid,
    output logic [7:0] arg_data,
    output logic rsp_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic stall = 1'b0;
    logic done;
    int n;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_write = 1'b0;
        arg_valid = 1'b0;
        arg_data = 8'h00;
        rsp_ready = 1'b1;
    end
    // ========================================
    // Command transfer
    // Released opcode and argument data lines are inverted so a stale value can never pass for a fresh one.
    task automatic xfer(input logic [7:0] op, input logic wr);
        rx_q.delete();
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_opcode <= op;
        cmd_write <= wr;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        cmd_opcode <= ~op;
        foreach (tx_q[i])
        begin
            arg_valid <= 1'b1;
            arg_data <= tx_q[i];
            do @(posedge clk); while (arg_ready !== 1'b1);
        end
        arg_valid <= 1'b0;
        arg_data <= ~arg_data;
        tx_q.delete();
        done = wr;
        n = 0;
        while (!done && n < 40)
        begin
            @(posedge clk);
            if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
            begin
                rx_q.push_back(rsp_data);
                done = rsp_last;
            end
            // Once the last byte is taken the line is left high for the next command.
            rsp_ready <= (stall && !done) ? ~rsp_ready : 1'b1;
            n++;
        end
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, ce, cmd_valid, cmd_write, cmd_ready, arg_valid, arg_ready;
    logic rsp_valid, rsp_last, rsp_ready, source_present_pin, fallback_splash, power_done;
    logic low_power, low_latency_en, look_load, source_def_change;
    logic [7:0] cmd_opcode, arg_data, rsp_data, power_state, source_sel, shown_source;
    logic [47:0] res_peak, res_now;
    logic [15:0] free_offset, look_index, v;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int miscompares = 0, checks = 0, pulses = 0, exp_src = 0, n;
    gocmd_handler DUT (.clk, .nrst, .ce, .cmd_valid, .cmd_opcode, .cmd_write, .cmd_ready,
        .arg_valid, .arg_data, .arg_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready,
        .res_peak, .res_now, .free_offset, .source_present_pin, .fallback_splash,
        .power_done, .power_state, .low_power, .source_sel, .shown_source, .low_latency_en,
        .look_index, .look_load, .source_def_change);
    gocmd_host u_host (.clk, .cmd_ready, .arg_ready, .rsp_valid, .rsp_data, .rsp_last,
        .cmd_valid, .cmd_opcode, .cmd_write, .arg_valid, .arg_data, .rsp_ready);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (look_load === 1'b1 && source_def_change === 1'b1) pulses++;
    // ========================================
    // Checking helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic get(input logic [7:0] op);
        u_host.xfer(op, 1'b0);
        chk(16'(u_host.rx_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) chk(16'(u_host.rx_q[i]), 16'(exp_q[i]));
    endtask
    // A set lands one edge after its last byte, so three edges leave it settled.
    task automatic set(input logic [7:0] op);
        u_host.xfer(op, 1'b1);
        repeat (3) @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100_000;
        miscompares++;
        test_done;
    end
    // ========================================
    // Main sequence
    initial
    begin
        seed = 32'hb93e_b653;
        nrst = 1'b0;
        ce = 1'b1;
        source_present_pin = 1'b1;
        fallback_splash = 1'b0;
        power_done = 1'b0;
        res_peak = 48'h0000_0000_0000;
        res_now = 48'h0000_0000_0000;
        free_offset = 16'h0000;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        res_peak <= 48'({$random(seed), $random(seed)});
        res_now <= 48'({$random(seed), $random(seed)});
        free_offset <= 16'($random(seed));
        @(posedge clk);
        chk(16'(low_power), 16'h0001);
        chk(16'(power_state), 16'(gocmd_pkg::PWR_STANDBY));
        for (int k = 0; k < 12; k++)
            exp_q.push_back(k < 6 ? res_peak[8*k +: 8] : res_now[8*k-48 +: 8]);
        u_host.stall = 1'b1;
        get(8'hF2);
        u_host.stall = 1'b0;
        exp_q = {free_offset[7:0], free_offset[15:8]};
        get(8'hFF);
        for (int s = 0; s < 6; s++)
        begin
            u_host.tx_q = {8'(s)};
            set(8'h11);
            exp_src = s < 5 ? s : exp_src;
            repeat (2) @(posedge clk);
            chk(16'(source_sel), 16'(exp_src));
            chk(16'(shown_source), 16'(exp_src));
            exp_q = {8'(exp_src)};
            get(8'h11);
        end
        source_present_pin <= 1'b0;
        for (int f = 0; f < 2; f++)
        begin
            fallback_splash <= f[0];
            u_host.tx_q = {8'h00};
            set(8'h11);
            repeat (8) @(posedge clk);
            exp_q = {f ? 8'h03 : 8'h02};
            chk(16'(shown_source), 16'(exp_q[0]));
            get(8'h11);
        end
        repeat (4)
        begin
            v = 16'($random(seed));
            u_host.tx_q = {v[7:0]};
            set(8'h12);
            chk(16'(low_latency_en), 16'(v[0]));
            exp_q = {8'(v[0])};
            get(8'h12);
        end
        repeat (3)
        begin
            v = 16'($random(seed));
            u_host.tx_q = {v[7:0], v[15:8]};
            n = pulses;
            set(8'h13);
            chk(look_index, v);
            chk(16'(pulses - n), 16'h0001);
            exp_q = {v[7:0], v[15:8]};
            get(8'h13);
        end
        for (int p = 0; p < 2; p++)
        begin
            set(8'h10);
            set(8'h10);
            chk(16'(power_state), p ? 16'h0003 : 16'h0004);
            // With the clock enable low, a completion report must not move the state.
            ce <= 1'b0;
            power_done <= 1'b1;
            repeat (3) @(posedge clk);
            chk(16'(power_state), p ? 16'h0003 : 16'h0004);
            ce <= 1'b1;
            @(posedge clk);
            power_done <= 1'b0;
            repeat (2) @(posedge clk);
            exp_q = {p ? 8'h01 : 8'h02};
            chk(16'(power_state), 16'(exp_q[0]));
            chk(16'(low_power), 16'(p));
            get(8'h10);
        end
        exp_q = {};
        get(8'h20);
        test_done;
    end
endmodule
`default_nettype wire
